// ---- rtl/hirq_top.sv ----
/*
 * Host interrupt request output of a serial data-bus terminal, with its
 * status and mask registers, master clear and self-test start gating.
 * Assumes events arrive as one-cycle pulses on the block's own clock and
 * that the register port follows the one-cycle strobe protocol.
 */
`timescale 1ns/1ps
`default_nettype none
module hirq_top (
    input  wire logic                   clock_i,
    input  wire logic                   reset_i,
    input  wire logic                   global_clear_n_i,
    input  wire logic                   selftest_after_reset_strap_i,
    input  wire logic [hirq_pkg::AW-1:0] addr_i,
    input  wire logic [hirq_pkg::DW-1:0] wdata_i,
    input  wire logic                   wr_i,
    input  wire logic                   rd_i,
    input  wire logic [hirq_pkg::DW-1:0] event1_i,
    input  wire logic [hirq_pkg::DW-1:0] event2_i,
    output logic      [hirq_pkg::DW-1:0] rdata_o,
    output logic                        int_n_o,
    output logic                        irq_o,
    output logic                        selftest_start_o
);
    import hirq_pkg::*;

    logic              clr_n_s;
    logic              strap_s;
    logic              rst;
    logic              tmr_busy;
    logic              tmr_done;
    logic              tmr_start;
    logic [DW-1:0]     cfg2_q, cfg2_d;
    logic [DW-1:0]     mask1_q, mask1_d;
    logic [DW-1:0]     mask2_q, mask2_d;
    logic [DW-1:0]     stat1_q, stat1_d;
    logic [DW-1:0]     stat2_q, stat2_d;
    logic [1:0]        clksel_q, clksel_d;
    logic [IRQ_W-1:0]  hstat_q, hstat_d;
    logic [IRQ_W-1:0]  hmask_q, hmask_d;
    logic              req1_q, req1_d;
    logic              req2_q, req2_d;
    hirq_state_t       st_q, st_d;
    logic              int_n_q, int_n_d;
    logic              irq_q, irq_d;
    logic [1:0]        boot_q, boot_d;
    logic              test_q, test_d;
    logic [DW-1:0]     rdata_q, rdata_d;
    logic              level_mode;
    logic              autoclr;
    logic              new1, new2;
    logic              int_clr_wr;
    logic              rd_stat1, rd_stat2;

    // Master clear is a pin, so it is synchronised before it resets logic.
    hirq_sync #(.W(1), .RESET_VAL(1'b1)) u_clr_sync (
        .clock_i (clock_i),
        .reset_i (reset_i),
        .d_i     (global_clear_n_i),
        .q_o     (clr_n_s)
    );

    hirq_sync #(.W(1), .RESET_VAL(1'b0)) u_strap_sync (
        .clock_i (clock_i),
        .reset_i (reset_i),
        .d_i     (selftest_after_reset_strap_i),
        .q_o     (strap_s)
    );

    assign rst = reset_i | ~clr_n_s;

    hirq_pulse_timer #(.CW(PULSE_CW)) u_timer (
        .clock_i (clock_i),
        .reset_i (rst),
        .start_i (tmr_start),
        .load_i  (hirq_pulse_cycles(clksel_q)),
        .busy_o  (tmr_busy),
        .done_o  (tmr_done)
    );

    function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
        return a == off;
    endfunction

    assign level_mode = cfg2_q[CFG2_LEVEL_BIT];
    assign autoclr    = cfg2_q[CFG2_AUTOCLR_BIT];
    assign new1       = |(event1_i & mask1_q);
    assign new2       = |(event2_i & mask2_q);
    assign int_clr_wr = wr_i && hit(addr_i, REG_START) && wdata_i[START_INTCLR_BIT];
    assign rd_stat1   = rd_i && hit(addr_i, REG_STAT1);
    assign rd_stat2   = rd_i && hit(addr_i, REG_STAT2);

    // Register file and status. New events win over a clear in the same cycle.
    always_comb begin
        cfg2_d   = cfg2_q;
        mask1_d  = mask1_q;
        mask2_d  = mask2_q;
        clksel_d = clksel_q;
        hmask_d  = hmask_q;
        stat1_d  = stat1_q;
        stat2_d  = stat2_q;
        hstat_d  = hstat_q;
        rdata_d  = '0;
        if (wr_i) begin
            case (addr_i)
                REG_CFG2:     cfg2_d   = wdata_i;
                REG_MASK1:    mask1_d  = wdata_i;
                REG_MASK2:    mask2_d  = wdata_i;
                REG_CLKSEL:   clksel_d = wdata_i[1:0];
                REG_IRQ_MASK: hmask_d  = wdata_i[IRQ_W-1:0];
                REG_STAT1:    stat1_d  = stat1_q & ~wdata_i;
                REG_STAT2:    stat2_d  = stat2_q & ~wdata_i;
                REG_IRQ_STAT: hstat_d  = hstat_q & ~wdata_i[IRQ_W-1:0];
                default:      cfg2_d   = cfg2_q;
            endcase
        end
        // Auto-clear also empties the status register that was read.
        if (rd_stat1 && autoclr) begin
            stat1_d = '0;
        end
        if (rd_stat2 && autoclr) begin
            stat2_d = '0;
        end
        stat1_d = stat1_d | event1_i;
        stat2_d = stat2_d | event2_i;
        if (st_q == HIRQ_IDLE && st_d != HIRQ_IDLE) begin
            hstat_d[IRQB_REQ] = 1'b1;
        end
        if (test_d) begin
            hstat_d[IRQB_TEST] = 1'b1;
        end
        if (rd_i) begin
            case (addr_i)
                REG_CFG2:     rdata_d = cfg2_q;
                REG_MASK1:    rdata_d = mask1_q;
                REG_MASK2:    rdata_d = mask2_q;
                REG_STAT1:    rdata_d = stat1_q;
                REG_STAT2:    rdata_d = stat2_q;
                REG_CLKSEL:   rdata_d = {14'h0000, clksel_q};
                REG_IRQ_STAT: rdata_d = {14'h0000, hstat_q};
                REG_IRQ_MASK: rdata_d = {14'h0000, hmask_q};
                REG_STATE:    rdata_d = {9'h000, strap_s, req2_q, req1_q, int_n_q, st_q};
                default:      rdata_d = '0;
            endcase
        end
        irq_d = |(hstat_d & hmask_d);
    end

    // Pending flags per status register; each is released on its own read.
    always_comb begin
        req1_d = req1_q;
        req2_d = req2_q;
        if (int_clr_wr) begin
            req1_d = 1'b0;
            req2_d = 1'b0;
        end
        if (autoclr && rd_stat1) begin
            req1_d = 1'b0;
        end
        if (autoclr && rd_stat2) begin
            req2_d = 1'b0;
        end
        req1_d = req1_d | new1;
        req2_d = req2_d | new2;
    end

    // Request line sequencer. Events during a pulse merge into that pulse.
    always_comb begin
        st_d      = st_q;
        tmr_start = 1'b0;
        case (st_q)
            HIRQ_IDLE: begin
                if (level_mode && (req1_d || req2_d)) begin
                    st_d = HIRQ_LEVEL;
                end else if (!level_mode && (new1 || new2)) begin
                    st_d      = HIRQ_PULSE;
                    tmr_start = 1'b1;
                end
            end
            HIRQ_PULSE: begin
                if (tmr_done) begin
                    st_d = HIRQ_IDLE;
                end
            end
            HIRQ_LEVEL: begin
                if (!level_mode || !(req1_d || req2_d)) begin
                    st_d = HIRQ_IDLE;
                end
            end
            default: st_d = HIRQ_IDLE;
        endcase
        int_n_d = (st_d == HIRQ_IDLE);
    end

    // The strap is read only once it has passed the synchroniser.
    always_comb begin
        boot_d = boot_q;
        test_d = 1'b0;
        if (boot_q != BOOT_WAIT) begin
            boot_d = boot_q + 2'h1;
            if (boot_d == BOOT_WAIT) begin
                test_d = strap_s;
            end
        end
        if (wr_i && hit(addr_i, REG_START) && wdata_i[START_TEST_BIT] && strap_s) begin
            test_d = 1'b1;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst) begin
            cfg2_q   <= CFG2_RESET;
            mask1_q  <= MASK_RESET;
            mask2_q  <= MASK_RESET;
            stat1_q  <= '0;
            stat2_q  <= '0;
            clksel_q <= CLKSEL_RESET;
            hstat_q  <= '0;
            hmask_q  <= '0;
            req1_q   <= 1'b0;
            req2_q   <= 1'b0;
            st_q     <= HIRQ_IDLE;
            int_n_q  <= 1'b1;
            irq_q    <= 1'b0;
            boot_q   <= 2'h0;
            test_q   <= 1'b0;
            rdata_q  <= '0;
        end else begin
            cfg2_q   <= cfg2_d;
            mask1_q  <= mask1_d;
            mask2_q  <= mask2_d;
            stat1_q  <= stat1_d;
            stat2_q  <= stat2_d;
            clksel_q <= clksel_d;
            hstat_q  <= hstat_d;
            hmask_q  <= hmask_d;
            req1_q   <= req1_d;
            req2_q   <= req2_d;
            st_q     <= st_d;
            int_n_q  <= int_n_d;
            irq_q    <= irq_d;
            boot_q   <= boot_d;
            test_q   <= test_d;
            rdata_q  <= rdata_d;
        end
    end

    assign rdata_o          = rdata_q;
    assign int_n_o          = int_n_q;
    assign irq_o            = irq_q;
    assign selftest_start_o = test_q;

    property p_pulse_start;
        @(posedge clock_i) disable iff (rst)
        (st_q == HIRQ_IDLE && !level_mode && (new1 || new2)) |=> !int_n_o;
    endproperty
    a_pulse_start: assert property (p_pulse_start) else $error("pulse request did not start");

    property p_pulse_width;
        @(posedge clock_i) disable iff (rst)
        $rose(st_q == HIRQ_PULSE) |-> !int_n_o [*5];
    endproperty
    a_pulse_width: assert property (p_pulse_width) else $error("pulse request too short");

    property p_pulse_end;
        @(posedge clock_i) disable iff (rst)
        (st_q == HIRQ_PULSE && tmr_done) |=> int_n_o;
    endproperty
    a_pulse_end: assert property (p_pulse_end) else $error("pulse request not released");

    property p_level_hold;
        @(posedge clock_i) disable iff (rst)
        (st_q == HIRQ_LEVEL && level_mode && !wr_i && !rd_i) |=> !int_n_o;
    endproperty
    a_level_hold: assert property (p_level_hold) else $error("level request dropped early");

    property p_int_clear;
        @(posedge clock_i) disable iff (rst)
        (int_clr_wr && level_mode && st_q != HIRQ_PULSE && !new1 && !new2) |=> int_n_o;
    endproperty
    a_int_clear: assert property (p_int_clear) else $error("clear write left request low");

    property p_autoclr;
        @(posedge clock_i) disable iff (rst)
        (level_mode && autoclr && st_q != HIRQ_PULSE && rd_stat1 && !req2_q && !new1 && !new2) |=> int_n_o;
    endproperty
    a_autoclr: assert property (p_autoclr) else $error("status read did not release request");

    property p_mask;
        @(posedge clock_i) disable iff (rst)
        (st_q == HIRQ_IDLE && !new1 && !new2 && !(level_mode && (req1_q || req2_q))) |=> int_n_o;
    endproperty
    a_mask: assert property (p_mask) else $error("request raised without enabled event");

    property p_both;
        @(posedge clock_i) disable iff (rst)
        (st_q == HIRQ_LEVEL && level_mode && autoclr && req1_q && req2_q && rd_stat1 && !int_clr_wr) |=> !int_n_o;
    endproperty
    a_both: assert property (p_both) else $error("request released before both reads");

    property p_clear_reset;
        @(posedge clock_i)
        $past(rst) |-> (int_n_o && !selftest_start_o);
    endproperty
    a_clear_reset: assert property (p_clear_reset) else $error("reset left outputs active");

    property p_boot_test;
        @(posedge clock_i) disable iff (rst)
        (boot_q == 2'h2 && strap_s) |=> selftest_start_o;
    endproperty
    a_boot_test: assert property (p_boot_test) else $error("self-test not started after reset");

    property p_test_gate;
        @(posedge clock_i) disable iff (rst)
        selftest_start_o |-> $past(strap_s);
    endproperty
    a_test_gate: assert property (p_test_gate) else $error("self-test started with strap low");
endmodule // hirq_top
`default_nettype wire

// ---- rtl/hirq_pkg.sv ----
/*
 * Shared constants for the host interrupt request block: register
 * offsets, field positions, reset values, pulse timing and states.
 * Assumes a single master clock in one of the four supported rates.
 */
package hirq_pkg;

    localparam int          DW               = 16;
    localparam int          AW               = 4;

    localparam logic [3:0]  REG_CFG2         = 4'h0;
    localparam logic [3:0]  REG_START        = 4'h1;
    localparam logic [3:0]  REG_MASK1        = 4'h2;
    localparam logic [3:0]  REG_MASK2        = 4'h3;
    localparam logic [3:0]  REG_STAT1        = 4'h4;
    localparam logic [3:0]  REG_STAT2        = 4'h5;
    localparam logic [3:0]  REG_IRQ_STAT     = 4'h6;
    localparam logic [3:0]  REG_IRQ_MASK     = 4'h7;
    localparam logic [3:0]  REG_STATE        = 4'h8;
    localparam logic [3:0]  REG_CLKSEL       = 4'h9;

    localparam int          CFG2_LEVEL_BIT   = 3;
    localparam int          CFG2_AUTOCLR_BIT = 4;
    localparam int          START_TEST_BIT   = 1;
    localparam int          START_INTCLR_BIT = 2;
    localparam int          IRQB_REQ         = 0;
    localparam int          IRQB_TEST        = 1;
    localparam int          IRQ_W            = 2;

    localparam logic [15:0] CFG2_RESET       = 16'h0000;
    localparam logic [15:0] MASK_RESET       = 16'h0000;
    localparam logic [1:0]  CLKSEL_RESET     = 2'h0;

    // Pulse width in ns and the supported master clock rates in MHz.
    localparam int          PULSE_NS         = 500;
    localparam int          MHZ_SEL0         = 20;
    localparam int          MHZ_SEL1         = 16;
    localparam int          MHZ_SEL2         = 12;
    localparam int          MHZ_SEL3         = 10;
    localparam int          PULSE_CW         = 5;
    localparam logic [1:0]  BOOT_WAIT        = 2'h3;

    typedef enum logic [2:0] {
        HIRQ_IDLE  = 3'b001,
        HIRQ_PULSE = 3'b010,
        HIRQ_LEVEL = 3'b100
    } hirq_state_t;

    // Cycles for a pulse of at least PULSE_NS at the selected rate.
    function automatic logic [PULSE_CW-1:0] hirq_pulse_cycles(input logic [1:0] sel);
        int mhz;
        case (sel)
            2'h0:    mhz = MHZ_SEL0;
            2'h1:    mhz = MHZ_SEL1;
            2'h2:    mhz = MHZ_SEL2;
            default: mhz = MHZ_SEL3;
        endcase
        return PULSE_CW'((PULSE_NS * mhz + 999) / 1000);
    endfunction

endpackage

// ---- rtl/hirq_sync.sv ----
/*
 * Two-flop synchroniser for pin levels.
 * Assumes the input is a slow level from outside the clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
module hirq_sync #(
    parameter int         W         = 1,
    parameter logic [0:0] RESET_VAL = 1'b0
) (
    input  wire logic         clock_i,
    input  wire logic         reset_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] sync_q;
    logic [W-1:0] sync_d;

    generate
        if (W < 1) begin : g_chk
            $error("hirq_sync width must be at least one");
        end
    endgenerate

    // The first stage is read only by the second.
    always_comb begin
        meta_d = d_i;
        sync_d = meta_q;
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            meta_q <= {W{RESET_VAL}};
            sync_q <= {W{RESET_VAL}};
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign q_o = sync_q;
endmodule // hirq_sync
`default_nettype wire

// ---- rtl/hirq_pulse_timer.sv ----
/*
 * Down counter that times the pulse-mode request width.
 * Assumes start is a one-cycle strobe and load is at least one.
 */
`timescale 1ns/1ps
`default_nettype none
module hirq_pulse_timer #(
    parameter int CW = 5
) (
    input  wire logic          clock_i,
    input  wire logic          reset_i,
    input  wire logic          start_i,
    input  wire logic [CW-1:0] load_i,
    output logic               busy_o,
    output logic               done_o
);
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic          busy_q;
    logic          busy_d;

    generate
        if (CW < 4) begin : g_chk
            $error("hirq_pulse_timer needs at least four count bits");
        end
    endgenerate

    // Busy lasts exactly load_i cycles after the start strobe.
    always_comb begin
        cnt_d  = cnt_q;
        busy_d = busy_q;
        if (start_i) begin
            cnt_d  = load_i - CW'(1);
            busy_d = 1'b1;
        end else if (busy_q) begin
            if (cnt_q == '0) begin
                busy_d = 1'b0;
            end else begin
                cnt_d = cnt_q - CW'(1);
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            cnt_q  <= '0;
            busy_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            busy_q <= busy_d;
        end
    end

    assign busy_o = busy_q;
    assign done_o = busy_q && (cnt_q == '0);
endmodule // hirq_pulse_timer
`default_nettype wire

// ---- bench/hirq_host_model.sv ----
/*
 * Host processor model for the interrupt request block: register writes and reads.
 * Assumes the one-cycle strobe port with read data standing in the cycle after the strobe.
 */
`timescale 1ns/1ps
`default_nettype none
module hirq_host_model (
    input  wire logic                     clock_i,
    input  wire logic [hirq_pkg::DW-1:0]  rdata_i,
    output logic      [hirq_pkg::AW-1:0]  addr_o,
    output logic      [hirq_pkg::DW-1:0]  wdata_o,
    output logic                          wr_o,
    output logic                          rd_o
);
    import hirq_pkg::*;

    initial begin
        addr_o  = '0;
        wdata_o = '0;
        wr_o    = 1'b0;
        rd_o    = 1'b0;
    end

    // Released bus lines show the inverse so stale values are never mistaken for live ones.
    task automatic write_reg(input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge clock_i);
        addr_o  <= a;
        wdata_o <= d;
        wr_o    <= 1'b1;
        @(posedge clock_i);
        wr_o    <= 1'b0;
        addr_o  <= ~a;
        wdata_o <= ~d;
    endtask

    task automatic read_reg(input logic [AW-1:0] a, output logic [DW-1:0] d);
        @(posedge clock_i);
        addr_o <= a;
        rd_o   <= 1'b1;
        @(posedge clock_i);
        rd_o   <= 1'b0;
        addr_o <= ~a;
        // Read data stand only until the next edge, so take them once settled.
        #1;
        d = rdata_i;
    endtask
endmodule // hirq_host_model
`default_nettype wire

// ---- bench/tb_top.sv ----
/*
 * Self-checking bench for the host interrupt request block.
 * Assumes the host model speaks the register port and events are one-cycle pulses.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import hirq_pkg::*;

    logic          clock_i;
    logic          reset_i;
    logic          global_clear_n;
    logic          strap;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic [DW-1:0] rdata;
    logic [DW-1:0] event1;
    logic [DW-1:0] event2;
    logic          wr;
    logic          rd;
    logic          int_n;
    logic          irq;
    logic          st;
    int            failures;
    int            num_checks;
    int            n;
    int            mhz [4] = '{MHZ_SEL0, MHZ_SEL1, MHZ_SEL2, MHZ_SEL3};

    hirq_top DUT (
        .clock_i                      (clock_i),
        .reset_i                      (reset_i),
        .global_clear_n_i             (global_clear_n),
        .selftest_after_reset_strap_i (strap),
        .addr_i                       (addr),
        .wdata_i                      (wdata),
        .wr_i                         (wr),
        .rd_i                         (rd),
        .event1_i                     (event1),
        .event2_i                     (event2),
        .rdata_o                      (rdata),
        .int_n_o                      (int_n),
        .irq_o                        (irq),
        .selftest_start_o             (st)
    );

    hirq_host_model host (
        .clock_i (clock_i),
        .rdata_i (rdata),
        .addr_o  (addr),
        .wdata_o (wdata),
        .wr_o    (wr),
        .rd_o    (rd)
    );

    initial begin
        clock_i = 1'b0;
        forever #2 clock_i = ~clock_i;
    end

    task automatic final_report;
        $display("Checks %0d, mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", name, exp, got);
            failures++;
        end
    endtask

    task automatic chk1(input string name, input logic exp, input logic got);
        check(name, {15'h0000, exp}, {15'h0000, got});
    endtask

    task automatic rd_chk(input logic [AW-1:0] a, input logic [15:0] exp, input string name);
        logic [DW-1:0] d;
        host.read_reg(a, d);
        check(name, exp, d);
    endtask

    task automatic wait_cyc(input int k);
        repeat (k) @(posedge clock_i);
        #1;
    endtask

    task automatic ev(input logic [DW-1:0] e1, input logic [DW-1:0] e2);
        @(posedge clock_i);
        event1 <= e1;
        event2 <= e2;
        @(posedge clock_i);
        event1 <= 16'h0000;
        event2 <= 16'h0000;
    endtask

    // Counts the first run of low request cycles; zero if the line never drops.
    task automatic low_len(output int cnt);
        cnt = 0;
        for (int k = 0; k < 40; k++) begin
            @(posedge clock_i);
            if (int_n === 1'b0) begin
                cnt++;
            end else if (cnt > 0) begin
                break;
            end
        end
    endtask

    task automatic st_count(input int k, output int cnt);
        cnt = 0;
        repeat (k) begin
            @(posedge clock_i);
            if (st === 1'b1) begin
                cnt++;
            end
        end
    endtask

    task automatic do_reset(input logic s, output int cnt);
        @(posedge clock_i);
        strap   <= s;
        reset_i <= 1'b1;
        repeat (10) @(posedge clock_i);
        reset_i <= 1'b0;
        st_count(12, cnt);
    endtask

    initial begin
        #(20000 * 4);
        failures++;
        final_report();
    end

    initial begin
        reset_i        = 1'b1;
        global_clear_n = 1'b1;
        strap          = 1'b1;
        event1         = 16'h0000;
        event2         = 16'h0000;
        failures       = 0;
        num_checks     = 0;
        do_reset(1'b1, n);
        check("boot_selftest", 16'h0001, 16'(n));
        rd_chk(REG_CFG2, CFG2_RESET, "cfg2_reset");
        rd_chk(REG_MASK1, MASK_RESET, "mask1_reset");
        rd_chk(REG_CLKSEL, {14'h0000, CLKSEL_RESET}, "clksel_reset");
        rd_chk(4'hF, 16'h0000, "unmapped");
        rd_chk(REG_START, 16'h0000, "start_reads_zero");
        chk1("int_n_idle", 1'b1, int_n);
        chk1("irq_idle", 1'b0, irq);
        host.write_reg(REG_START, 16'h0002);
        st_count(3, n);
        check("cmd_selftest", 16'h0001, 16'(n));
        do_reset(1'b0, n);
        check("boot_selftest_off", 16'h0000, 16'(n));
        host.write_reg(REG_START, 16'h0002);
        st_count(3, n);
        check("cmd_selftest_off", 16'h0000, 16'(n));
        host.write_reg(REG_MASK1, 16'h0001);
        for (int s = 0; s < 4; s++) begin
            host.write_reg(REG_CLKSEL, 16'(s));
            ev(16'h0001, 16'h0000);
            low_len(n);
            check("pulse_width", 16'((PULSE_NS * mhz[s] + 999) / 1000), 16'(n));
        end
        ev(16'h0002, 16'h0000);
        low_len(n);
        check("masked_event", 16'h0000, 16'(n));
        rd_chk(REG_STAT1, 16'h0003, "stat1_sticky");
        host.write_reg(REG_CFG2, 16'h0008);
        host.write_reg(REG_START, 16'h0004);
        wait_cyc(1);
        chk1("level_idle", 1'b1, int_n);
        ev(16'h0001, 16'h0000);
        wait_cyc(20);
        chk1("level_held", 1'b0, int_n);
        host.write_reg(REG_START, 16'h0004);
        wait_cyc(2);
        chk1("level_cleared", 1'b1, int_n);
        host.write_reg(REG_STAT1, 16'hFFFF);
        host.write_reg(REG_CFG2, 16'h0018);
        host.write_reg(REG_MASK2, 16'h0001);
        ev(16'h0001, 16'h0001);
        wait_cyc(2);
        chk1("both_pending", 1'b0, int_n);
        rd_chk(REG_STAT1, 16'h0001, "stat1_read");
        wait_cyc(2);
        chk1("one_read", 1'b0, int_n);
        rd_chk(REG_STAT2, 16'h0001, "stat2_read");
        wait_cyc(2);
        chk1("both_read", 1'b1, int_n);
        rd_chk(REG_STAT1, 16'h0000, "stat1_autocleared");
        ev(16'h0000, 16'h0001);
        wait_cyc(2);
        chk1("stat2_pending", 1'b0, int_n);
        rd_chk(REG_STAT2, 16'h0001, "stat2_only");
        wait_cyc(2);
        chk1("stat2_released", 1'b1, int_n);
        host.write_reg(REG_IRQ_MASK, 16'h0001);
        wait_cyc(2);
        chk1("irq_raised", 1'b1, irq);
        host.write_reg(REG_IRQ_MASK, 16'h0000);
        wait_cyc(2);
        chk1("irq_masked", 1'b0, irq);
        host.write_reg(REG_IRQ_MASK, 16'h0001);
        host.write_reg(REG_IRQ_STAT, 16'h0001);
        wait_cyc(2);
        chk1("irq_cleared", 1'b0, irq);
        rd_chk(REG_IRQ_STAT, 16'h0000, "irq_stat_cleared");
        host.write_reg(REG_CFG2, 16'h0008);
        ev(16'h0001, 16'h0000);
        wait_cyc(2);
        chk1("level_before_clear", 1'b0, int_n);
        @(posedge clock_i);
        global_clear_n <= 1'b0;
        repeat (6) @(posedge clock_i);
        global_clear_n <= 1'b1;
        wait_cyc(4);
        chk1("clear_releases", 1'b1, int_n);
        rd_chk(REG_CFG2, CFG2_RESET, "cfg2_after_clear");
        rd_chk(REG_MASK1, MASK_RESET, "mask1_after_clear");
        rd_chk(REG_STATE, 16'h0009, "state_after_clear");
        final_report();
    end
endmodule // tb_top
`default_nettype wire
